//--- core/besq_pkg.sv
package besq_pkg;

    // ************************************************************
    // Code fields
    // ************************************************************
    localparam int CODE_W   = 8;
    localparam int OP_W     = 3;
    localparam int ADDR_W   = 5;
    localparam int NUM_ADDR = 30;

    localparam logic [4:0] ADDR_LOW  = 5'h00;
    localparam logic [4:0] ADDR_HIGH = 5'h1f;

    // Address-free codes, low field
    localparam logic [2:0] OP_RESTART = 3'h0;
    localparam logic [2:0] OP_INVERT  = 3'h1;
    localparam logic [2:0] OP_PAGE    = 3'h2;
    localparam logic [2:0] OP_HOME    = 3'h3;
    localparam logic [2:0] OP_PUSH0   = 3'h4;
    localparam logic [2:0] OP_PUSH1   = 3'h5;
    localparam logic [2:0] OP_PUSHC   = 3'h6;
    localparam logic [2:0] OP_POP     = 3'h7;

    // Pin direction options
    localparam logic [1:0] PIN_IN  = 2'h0;
    localparam logic [1:0] PIN_OUT = 2'h1;
    localparam logic [1:0] PIN_MUX = 2'h2;

    // Reset values
    localparam logic [7:0] PC_RST  = 8'h00;
    localparam logic       TOS_RST = 1'b1;

    typedef struct packed {
        logic [NUM_ADDR-1:0] pinIn;
        logic [CODE_W-1:0]   code;
    } besq_in_t;

endpackage

//--- core/besq_logic_unit.sv
`timescale 1ns/1ns
module besq_logic_unit (
    input  wire logic [1:0] func,
    input  wire logic       a,
    input  wire logic       b,
    output logic            result
);
    always_comb
    begin
        unique case (func)
            2'h0: result = a & b;
            2'h1: result = a | b;
            2'h2: result = a ^ b;
            default: result = ~(a ^ b);
        endcase
    end
endmodule

//--- core/besq_sequencer.sv
`timescale 1ns/1ns
// Contract
// - Logic unit does AND, OR, XOR, equality
// - Outputs change only at pass end
// - Restart relatches outputs, inputs, resets counter, top and page
// - Program counter advances every enabled cycle except restart
// - Every code completes in one cycle
// - Output buffers never readable as operands
// - All transfers pass through top of stack
// - Code is 8 bits: op low, address high
// - Addresses 1..30 select; 0, 31 address-free
// - All-zero code is restart
// - 001 invert, 004 push 0, 005 push 1
// - 006 push copy, 007 pop
// - 370..373 combine top two entries
// - 374..377 combine then push one
// - Pin direction fixed at build time
// - Page step and home codes
// - Store and output write top, set one
// - AND input or state into top
// - AND state then push one
module besq_sequencer #(
    parameter int          STACK_DEPTH                    = 8,
    parameter int          NUM_PAGES                      = 4,
    parameter logic [59:0] PIN_MODE                       = {30{2'h2}},
    parameter logic [2:0]  OP_STORE                       = 3'h0,
    parameter logic [2:0]  OP_OUTPUT                      = 3'h1,
    parameter logic [2:0]  OP_AND_WITH_INPUT              = 3'h2,
    parameter logic [2:0]  OP_AND_WITH_INVERTED_INPUT     = 3'h3,
    parameter logic [2:0]  OP_AND_WITH_STATE              = 3'h4,
    parameter logic [2:0]  OP_AND_WITH_INVERTED_STATE     = 3'h5,
    parameter logic [2:0]  OP_AND_STATE_PUSH_ONE          = 3'h6,
    parameter logic [2:0]  OP_AND_INVERTED_STATE_PUSH_ONE = 3'h7
) (
    input  wire logic        clock,
    input  wire logic        srst,
    input  wire logic        clkEn,
    input  wire logic [7:0]  code,
    input  wire logic [29:0] pinIn,
    output logic      [7:0]  progAddr,
    output logic      [29:0] pinOut,
    output logic      [29:0] pinOe
);
    localparam int PG_W = (NUM_PAGES > 1) ? $clog2(NUM_PAGES) : 1;

    // One-hot of each addressed op value; all eight must differ
    localparam logic [7:0] OP_SEEN = (8'h01 << OP_STORE) | (8'h01 << OP_OUTPUT)
        | (8'h01 << OP_AND_WITH_INPUT) | (8'h01 << OP_AND_WITH_INVERTED_INPUT)
        | (8'h01 << OP_AND_WITH_STATE) | (8'h01 << OP_AND_WITH_INVERTED_STATE)
        | (8'h01 << OP_AND_STATE_PUSH_ONE) | (8'h01 << OP_AND_INVERTED_STATE_PUSH_ONE);

    // Stack slices below need three entries
    if (STACK_DEPTH < 3 || NUM_PAGES < 1 || OP_SEEN != 8'hff)
    begin : g_badParam
        $error("Stack depth, page count or op values out of range");
    end

    typedef struct packed {
        logic [7:0]                  pc;
        logic [STACK_DEPTH-1:0]      stack;
        logic [PG_W-1:0]             page;
        logic [29:0]                 inLatch;
        logic [29:0]                 outBuf;
        logic [29:0]                 outDrv;
        logic [NUM_PAGES*30-1:0]     states;
    } besq_state_t;

    besq_state_t st_r;
    besq_state_t st_nxt;

    // ************************************************************
    // Decode
    // ************************************************************
    logic [2:0] op;
    logic [4:0] addr;
    logic       addrFree;
    logic [4:0] idx;
    logic       inBit;
    logic       ssBit;
    logic       luOut;
    logic       tos;
    logic       nos;

    assign op   = code[2:0];
    assign addr = code[7:3];
    assign addrFree = (addr == besq_pkg::ADDR_LOW) || (addr == besq_pkg::ADDR_HIGH);
    assign idx  = addrFree ? 5'h00 : addr - 5'h01;
    assign tos  = st_r.stack[0];
    assign nos  = st_r.stack[1];
    // operands only from input latches and states
    assign inBit = st_r.inLatch[idx];
    assign ssBit = st_r.states[st_r.page*30 + 32'(idx)];

    besq_logic_unit u_lu (
        .func   (op[1:0]),
        .a      (tos),
        .b      (nos),
        .result (luOut)
    );

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.pc = st_r.pc + 8'h01;
        if (addr == besq_pkg::ADDR_LOW)
        begin
            unique case (op)
                besq_pkg::OP_RESTART:
                begin
                    st_nxt.outDrv   = st_r.outBuf;
                    st_nxt.stack[0] = besq_pkg::TOS_RST;
                    st_nxt.page     = '0;
                    st_nxt.inLatch  = pinIn;
                    st_nxt.pc       = besq_pkg::PC_RST;
                end
                besq_pkg::OP_INVERT: st_nxt.stack[0] = ~tos;
                // page step wraps past last page
                besq_pkg::OP_PAGE:
                    st_nxt.page = (32'(st_r.page) == NUM_PAGES - 1) ? '0 : st_r.page + 1'b1;
                besq_pkg::OP_HOME:   st_nxt.page = '0;
                besq_pkg::OP_PUSH0:  st_nxt.stack = {st_r.stack[STACK_DEPTH-2:0], 1'b0};
                besq_pkg::OP_PUSH1:  st_nxt.stack = {st_r.stack[STACK_DEPTH-2:0], 1'b1};
                besq_pkg::OP_PUSHC:  st_nxt.stack = {st_r.stack[STACK_DEPTH-2:0], tos};
                default:             st_nxt.stack = {1'b0, st_r.stack[STACK_DEPTH-1:1]};
            endcase
        end
        else if (addr == besq_pkg::ADDR_HIGH)
        begin
            if (!op[2])
                st_nxt.stack = {1'b0, st_r.stack[STACK_DEPTH-1:2], luOut};
            else
                st_nxt.stack = {st_r.stack[STACK_DEPTH-1:2], luOut, 1'b1};
        end
        else
        begin
            if (op == OP_STORE)
            begin
                st_nxt.states[st_r.page*30 + 32'(idx)] = tos;
                st_nxt.stack[0] = 1'b1;
            end
            else if (op == OP_OUTPUT)
            begin
                st_nxt.outBuf[idx] = tos;
                st_nxt.stack[0] = 1'b1;
            end
            else if (op == OP_AND_WITH_INPUT)          st_nxt.stack[0] = tos & inBit;
            else if (op == OP_AND_WITH_INVERTED_INPUT) st_nxt.stack[0] = tos & ~inBit;
            else if (op == OP_AND_WITH_STATE)          st_nxt.stack[0] = tos & ssBit;
            else if (op == OP_AND_WITH_INVERTED_STATE) st_nxt.stack[0] = tos & ~ssBit;
            else if (op == OP_AND_STATE_PUSH_ONE)
                st_nxt.stack = {st_r.stack[STACK_DEPTH-2:1], tos & ssBit, 1'b1};
            else if (op == OP_AND_INVERTED_STATE_PUSH_ONE)
                st_nxt.stack = {st_r.stack[STACK_DEPTH-2:1], tos & ~ssBit, 1'b1};
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            st_r         <= '0;
            st_r.pc      <= besq_pkg::PC_RST;
            st_r.stack   <= {{(STACK_DEPTH-1){1'b0}}, besq_pkg::TOS_RST};
        end
        else if (clkEn)
            st_r <= st_nxt;
    end

    // ************************************************************
    // Pins
    // ************************************************************
    assign progAddr = st_r.pc;

    genvar g;
    generate
        for (g = 0; g < 30; g++)
        begin : g_pin
            // pins driven only from relatched drivers
            assign pinOut[g] = st_r.outDrv[g];
            assign pinOe[g]  = (PIN_MODE[2*g +: 2] != besq_pkg::PIN_IN);
            if (PIN_MODE[2*g +: 2] > besq_pkg::PIN_MUX)
            begin : g_badMode
                $error("Pin mode value not supported");
            end
        end
    endgenerate

    // ************************************************************
    // Checks
    // ************************************************************
    property p_outHold;
        @(posedge clock) disable iff (srst)
        (clkEn && code != 8'h00) |=> $stable(pinOut);
    endproperty
    a_outHold: assert property (p_outHold) else $error("Outputs changed mid pass");

    property p_restart;
        @(posedge clock) disable iff (srst)
        (clkEn && code == 8'h00) |=> (progAddr == 8'h00 && tos && st_r.page == '0 && pinOut == $past(st_r.outBuf));
    endproperty
    a_restart: assert property (p_restart) else $error("Restart actions missing");

    property p_pcStep;
        @(posedge clock) disable iff (srst)
        (clkEn && code != 8'h00) |=> progAddr == $past(progAddr) + 8'h01;
    endproperty
    a_pcStep: assert property (p_pcStep) else $error("Program counter did not step");

    property p_freeze;
        @(posedge clock) disable iff (srst)
        !clkEn |=> $stable(progAddr) && $stable(st_r.stack);
    endproperty
    a_freeze: assert property (p_freeze) else $error("State moved while disabled");

    property p_invert;
        @(posedge clock) disable iff (srst)
        (clkEn && code == 8'h01) |=> tos == !$past(tos) && nos == $past(nos);
    endproperty
    a_invert: assert property (p_invert) else $error("Invert wrong");

    property p_pushCopy;
        @(posedge clock) disable iff (srst)
        (clkEn && code == 8'h06) |=> tos == $past(tos) && nos == $past(tos);
    endproperty
    a_pushCopy: assert property (p_pushCopy) else $error("Push copy wrong");

    property p_logic;
        @(posedge clock) disable iff (srst)
        (clkEn && code == 8'hfb) |=> tos == ($past(tos) ~^ $past(nos));
    endproperty
    a_logic: assert property (p_logic) else $error("Equality wrong");

    property p_logicPush;
        @(posedge clock) disable iff (srst)
        (clkEn && code == 8'hfc) |=> tos && nos == ($past(tos) & $past(nos));
    endproperty
    a_logicPush: assert property (p_logicPush) else $error("And push wrong");

    property p_home;
        @(posedge clock) disable iff (srst)
        (clkEn && code == 8'h03) |=> st_r.page == '0;
    endproperty
    a_home: assert property (p_home) else $error("Home failed");

    property p_store;
        @(posedge clock) disable iff (srst)
        (clkEn && !addrFree && op == OP_OUTPUT) |=> tos && st_r.outBuf[$past(idx)] == $past(tos);
    endproperty
    a_store: assert property (p_store) else $error("Output store wrong");

    property p_stateWrite;
        @(posedge clock) disable iff (srst)
        (clkEn && !addrFree && op == OP_STORE) |=> tos && st_r.states[$past(st_r.page*30 + 32'(idx))] == $past(tos);
    endproperty
    a_stateWrite: assert property (p_stateWrite) else $error("State store wrong");

    property p_pageStep;
        @(posedge clock) disable iff (srst)
        (clkEn && code == 8'h02) |=>
            32'(st_r.page) == ((32'($past(st_r.page)) == NUM_PAGES - 1) ? 0 : 32'($past(st_r.page)) + 1);
    endproperty
    a_pageStep: assert property (p_pageStep) else $error("Page step wrong");

    property p_pushConst;
        @(posedge clock) disable iff (srst)
        (clkEn && (code == 8'h04 || code == 8'h05)) |=> tos == $past(code[0]) && nos == $past(tos);
    endproperty
    a_pushConst: assert property (p_pushConst) else $error("Push constant wrong");

    property p_pop;
        @(posedge clock) disable iff (srst)
        (clkEn && code == 8'h07) |=> tos == $past(nos) && !st_r.stack[STACK_DEPTH-1];
    endproperty
    a_pop: assert property (p_pop) else $error("Pop wrong");

    property p_restartIn;
        @(posedge clock) disable iff (srst)
        (clkEn && code == 8'h00) |=> st_r.inLatch == $past(pinIn);
    endproperty
    a_restartIn: assert property (p_restartIn) else $error("Inputs not latched");

    property p_andInput;
        @(posedge clock) disable iff (srst)
        (clkEn && !addrFree && op == OP_AND_WITH_INPUT) |=> tos == ($past(tos) & $past(inBit)) && nos == $past(nos);
    endproperty
    a_andInput: assert property (p_andInput) else $error("Input AND wrong");

    property p_andStatePush;
        @(posedge clock) disable iff (srst)
        (clkEn && !addrFree && op == OP_AND_STATE_PUSH_ONE) |=> tos && nos == ($past(tos) & $past(ssBit));
    endproperty
    a_andStatePush: assert property (p_andStatePush) else $error("State AND push wrong");

    property p_addrFree;
        @(posedge clock) disable iff (srst)
        (clkEn && addrFree) |=> $stable(st_r.outBuf) && $stable(st_r.states);
    endproperty
    a_addrFree: assert property (p_addrFree) else $error("Address-free code wrote storage");
endmodule

//--- bench/besq_prog_model.sv
`timescale 1ns/1ns
module besq_prog_model (
    input  wire logic [7:0]  progAddr,
    input  wire logic [29:0] extIn,
    output logic      [7:0]  code,
    output logic      [29:0] pinIn
);
    logic [7:0] mem [0:255];
    // Blank words read as restart, so short programs loop
    initial
    begin
        for (int i = 0; i < 256; i++)
            mem[i] = 8'h00;
    end
    assign code  = mem[progAddr];
    assign pinIn = extIn;
endmodule

//--- bench/boolean_equation_sequencer_tb_top.sv
`timescale 1ns/1ns
module boolean_equation_sequencer_tb_top;
    logic        clock;
    logic        srst;
    logic        clkEn;
    logic [29:0] extIn;
    logic [7:0]  code;
    logic [29:0] pinIn;
    logic [7:0]  progAddr;
    logic [29:0] pinOut;
    logic [29:0] pinOe;
    int          err_count;
    int          samples_checked;

    besq_sequencer #(
        .PIN_MODE (60'h8aaaaaaaaaaaaaa)
    ) besq_sequencer_inst (
        .clock    (clock),
        .srst     (srst),
        .clkEn    (clkEn),
        .code     (code),
        .pinIn    (pinIn),
        .progAddr (progAddr),
        .pinOut   (pinOut),
        .pinOe    (pinOe)
    );

    besq_prog_model besq_prog_model_inst (
        .progAddr (progAddr),
        .extIn    (extIn),
        .code     (code),
        .pinIn    (pinIn)
    );

    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic stop_test;
        $display("checked %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [29:0] got, input logic [29:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic load(input logic [7:0] p[$]);
        for (int i = 0; i < 256; i++)
            besq_prog_model_inst.mem[i] = (i < p.size()) ? p[i] : 8'h00;
    endtask

    task automatic rst;
        srst = 1'b1;
        repeat (4) @(negedge clock);
        srst = 1'b0;
        check({22'h0, progAddr}, 30'h0);
        check(pinOut, 30'h0);
        check(pinOe, 30'h2fffffff);
    endtask

    // Follows the counter and the drivers while passes run
    task automatic run(input int passes);
        logic [7:0]  pc;
        logic [7:0]  op;
        logic [29:0] po;
        int          n;
        n = 0;
        for (int i = 0; i < 400 && n < passes; i++)
        begin
            pc = progAddr;
            op = code;
            po = pinOut;
            @(negedge clock);
            if (op === 8'h00)
            begin
                n++;
                check({22'h0, progAddr}, 30'h0);
            end
            else
            begin
                check({22'h0, progAddr}, {22'h0, pc + 8'h01});
                check(pinOut, po);
            end
        end
        if (n < passes)
        begin
            err_count++;
            $display("mismatch at %0t: pass did not end", $time);
        end
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic logic_test;
        logic e;
        for (int f = 0; f < 4; f++)
            for (int a = 0; a < 2; a++)
                for (int b = 0; b < 2; b++)
                begin
                    e = (f == 0) ? 1'(a & b) : (f == 1) ? 1'(a | b) : (f == 2) ? 1'(a ^ b) : 1'(a == b);
                    load('{8'h04 | 8'(a), 8'h04 | 8'(b), 8'hf8 | 8'(f), 8'h09, 8'h04 | 8'(a),
                           8'h04 | 8'(b), 8'hfc | 8'(f), 8'h11, 8'h07, 8'h19});
                    rst();
                    run(1);
                    check(pinOut, {27'h0, e, 1'b1, e});
                end
        $display("logic_test done");
    endtask

    task automatic stack_test;
        logic [7:0] p[$];
        p = '{8'h01, 8'h09, 8'h04, 8'h06, 8'h01, 8'h11, 8'h07, 8'h19};
        // Overfill, then drain past the bottom
        for (int i = 0; i < 8; i++)
            p.push_back(8'h05);
        for (int i = 0; i < 8; i++)
            p.push_back(8'h07);
        p.push_back(8'h21);
        p.push_back(8'h05);
        p.push_back(8'h29);
        load(p);
        rst();
        clkEn = 1'b0;
        repeat (3) @(negedge clock);
        check({22'h0, progAddr}, 30'h0);
        clkEn = 1'b1;
        run(1);
        check(pinOut, 30'h12);
        $display("stack_test done");
    endtask

    task automatic io_test(input logic i3, input logic i4);
        logic [29:0] v;
        v = {26'h2aaaaaa, i4, i3, 2'b01};
        load('{8'h1a, 8'h09, 8'h1b, 8'h11, 8'h22, 8'h28, 8'h02, 8'h23, 8'h28, 8'h03, 8'h2c, 8'h19,
               8'h2d, 8'h21, 8'h02, 8'h2e, 8'h29, 8'h07, 8'h31, 8'h2f, 8'h07, 8'hf1});
        extIn = v;
        rst();
        run(1);
        // Pins move right after the restart latch, at pass start; only the latched copy may count
        extIn = ~v;
        run(1);
        check(pinOut, {i4, 23'h0, ~i4, 1'b1, ~i4, i4, ~i3, i3});
        $display("io_test done");
    endtask

    initial
    begin
        srst = 1'b1;
        clkEn = 1'b1;
        extIn = 30'h0;
        err_count = 0;
        samples_checked = 0;
        logic_test();
        stack_test();
        io_test(1'b1, 1'b0);
        io_test(1'b0, 1'b1);
        stop_test();
    end

    // Whole run is under 1000 cycles
    initial
    begin
        #2000000;
        err_count++;
        stop_test();
    end
endmodule
